// File: design/aghs_pkg.sv
// aghs_pkg: constants, register map and types for the group halt command block
// assumes: one core clock, apb slave registers, all inputs synchronous
package aghs_pkg;
	localparam int          GROUP_MIN     = 1;
	localparam int          GROUP_MAX     = 8;
	localparam int          GROUP_W       = 8;
	localparam int          FAULT_W       = 16;
	// apb register byte offsets
	localparam logic [11:0] OFS_CTRL      = 12'h000;
	localparam logic [11:0] OFS_CFG       = 12'h004;
	localparam logic [11:0] OFS_STATUS    = 12'h008;
	localparam logic [11:0] OFS_FAULT     = 12'h00C;
	localparam logic [11:0] OFS_GROUP     = 12'h010;
	// ctrl fields
	localparam int          CTRL_EXEC_BIT = 0;
	// cfg fields
	localparam int          CFG_GRP_LSB   = 0;
	localparam int          CFG_POL_LSB   = 8;
	localparam int          CFG_DEC_LSB   = 16;
	localparam int          CFG_JERK_LSB  = 24;
	// status fields
	localparam int          ST_BUSY       = 0;
	localparam int          ST_ACTIVE     = 1;
	localparam int          ST_DONE       = 2;
	localparam int          ST_ABORTED    = 3;
	localparam int          ST_ERROR      = 4;
	localparam int          ST_INHIBIT    = 5;
	localparam int          ST_HALT       = 6;
	// reset values
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [7:0]  POL_ABORT     = 8'h00;
	// fault codes
	localparam logic [15:0] FC_NONE       = 16'h0000;
	localparam logic [15:0] FC_BAD_GROUP  = 16'h0001;
	localparam logic [15:0] FC_BAD_POLICY = 16'h0002;
	localparam logic [15:0] FC_NOT_ARMED  = 16'h0003;
	localparam logic [15:0] FC_NOT_MOVING = 16'h0004;
	localparam logic [15:0] FC_EXEC_FAIL  = 16'h0005;

	typedef enum logic [2:0] {
		AG_IDLE    = 3'b000,
		AG_START   = 3'b001,
		AG_HALTING = 3'b010,
		AG_DONE    = 3'b011,
		AG_ABORTED = 3'b100,
		AG_ERROR   = 3'b101
	} aghs_state_t;
endpackage

// File: design/aghs_reg_if.sv
`timescale 1ns/1ps
// aghs_reg_if: carries the register view between the apb slave and the core
// assumes: both ends sit on core_clk
interface aghs_reg_if;
	logic        execReq;
	logic [7:0]  groupSel;
	logic [7:0]  queuePolicy;
	logic [7:0]  decelIn;
	logic [7:0]  jerkIn;
	logic [31:0] statusWord;
	logic [15:0] faultCode;
	logic [7:0]  latchedGroup;
	modport regs (output execReq, groupSel, queuePolicy, decelIn, jerkIn,
		input statusWord, faultCode, latchedGroup);
	modport core (input execReq, groupSel, queuePolicy, decelIn, jerkIn,
		output statusWord, faultCode, latchedGroup);
endinterface

// File: design/aghs_apb_regs.sv
`timescale 1ns/1ps
// aghs_apb_regs: apb slave holding the command registers
// assumes: zero wait state apb, word aligned accesses, pslverr on unmapped
module aghs_apb_regs
	import aghs_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// core side
	aghs_reg_if.regs         rif
);
	typedef struct packed {
		logic        exec;
		logic [31:0] cfg;
		logic [31:0] rdata;
	} aghs_regs_t;

	aghs_regs_t q;
	aghs_regs_t d;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == OFS_CTRL) || (a == OFS_CFG) || (a == OFS_STATUS) ||
			(a == OFS_FAULT) || (a == OFS_GROUP);
	endfunction

	logic access;
	assign access  = psel && penable;
	assign pready  = 1'b1;
	assign pslverr = access && !mapped(paddr);
	assign prdata  = q.rdata;

	always_comb begin
		d = q;
		if (access && pwrite && paddr == OFS_CTRL) begin
			d.exec = pwdata[CTRL_EXEC_BIT];
		end
		if (access && pwrite && paddr == OFS_CFG) begin
			d.cfg = pwdata;
		end
		// read data registered during setup so it is stable in the access phase
		if (psel && !penable && !pwrite) begin
			case (paddr)
				OFS_CTRL:   d.rdata = {31'h0000_0000, q.exec};
				OFS_CFG:    d.rdata = q.cfg;
				OFS_STATUS: d.rdata = rif.statusWord;
				OFS_FAULT:  d.rdata = {16'h0000, rif.faultCode};
				OFS_GROUP:  d.rdata = {24'h00_0000, rif.latchedGroup};
				default:    d.rdata = RST_WORD;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rif.execReq     = q.exec;
	assign rif.groupSel    = q.cfg[CFG_GRP_LSB +: 8];
	assign rif.queuePolicy = q.cfg[CFG_POL_LSB +: 8];
	assign rif.decelIn     = q.cfg[CFG_DEC_LSB +: 8];
	assign rif.jerkIn      = q.cfg[CFG_JERK_LSB +: 8];
endmodule

// File: design/aghs_group_halt.sv
`timescale 1ns/1ps
// aghs_group_halt: top of the group halt command handshake, one scan per clock
// assumes: motion generator reports per-group armed/moving/stopped levels
// Overview of operation
// - group number 1..8 is sampled only on the execute rising edge
// - only a rising execute edge starts a halt; steady high does nothing
// - deceleration and jerk inputs are ignored
// - queue policy other than 0 raises error
// - busy at the edge, active one scan later
// - done when motion stopped, busy and active stay high
// - execute falling clears done, busy, active, aborted and error
// - done also clears when error falls
// - abort sets aborted flag and drops busy and active until execute falls
// - failure or illegal inputs set error with fault code, drop busy and active
// - execute falling after error clears error and fault code
// - halt stops every axis of the group at once, no ramp
// - halt accepted only while a group move runs on that group
// - axes stay in group moving state after the halt
// - group moves inhibited after completion until execute falls
// - halt refused unless the group was armed
module aghs_group_halt
	import aghs_pkg::*;
#(
	parameter int GROUPS = GROUP_MAX
) (
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	// apb
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// motion generator status, one bit per group
	input  wire logic [GROUPS-1:0] groupArmed,
	input  wire logic [GROUPS-1:0] groupMoving,
	input  wire logic [GROUPS-1:0] groupStopped,
	input  wire logic [GROUPS-1:0] groupAbort,
	input  wire logic [GROUPS-1:0] groupFail,
	// motion generator control
	output logic [GROUPS-1:0]  groupHalt,
	output logic [GROUPS-1:0]  moveInhibit,
	// status
	output logic               busy,
	output logic               active,
	output logic               done,
	output logic               abortedFlag,
	output logic               error,
	output logic [15:0]        faultCode
);
	// elaboration-time refusal: the select decode only covers groups 1..GROUP_MAX
	if (GROUPS < 1 || GROUPS > GROUP_MAX) begin : g_groups_chk
		$error("GROUPS out of range");
	end

	aghs_reg_if rif ();

	aghs_apb_regs u_regs (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.rif      (rif)
	);

	typedef struct packed {
		aghs_state_t  st;
		logic         execPrev;
		logic [7:0]   grp;
		logic         busy;
		logic         active;
		logic         done;
		logic         aborted;
		logic         error;
		logic [15:0]  fault;
		logic [GROUPS-1:0] halt;
		logic [GROUPS-1:0] inhibit;
	} aghs_core_t;

	aghs_core_t q;
	aghs_core_t d;

	function automatic logic [GROUPS-1:0] grpMask(input logic [7:0] g);
		grpMask = '0;
		for (int i = 0; i < GROUPS; i++) begin
			if (g == 8'(i + GROUP_MIN)) begin
				grpMask[i] = 1'b1;
			end
		end
	endfunction

	logic              rise;
	logic              fall;
	logic [GROUPS-1:0] selNow;
	logic [GROUPS-1:0] selHeld;
	logic              grpOk;

	assign rise    = rif.execReq && !q.execPrev;
	assign fall    = !rif.execReq && q.execPrev;
	assign selNow  = grpMask(rif.groupSel);
	assign selHeld = grpMask(q.grp);
	assign grpOk   = |selNow;

	// rif.decelIn and rif.jerkIn are deliberately unread

	always_comb begin
		d = q;
		d.execPrev = rif.execReq;
		case (q.st)
			AG_IDLE: begin
				if (rise) begin
					d.grp  = rif.groupSel;
					d.busy = 1'b1;
					d.st   = AG_START;
					if (!grpOk) begin
						d.error = 1'b1;
						d.fault = FC_BAD_GROUP;
						d.busy  = 1'b0;
						d.st    = AG_ERROR;
					end else if (rif.queuePolicy != POL_ABORT) begin
						d.error = 1'b1;
						d.fault = FC_BAD_POLICY;
						d.busy  = 1'b0;
						d.st    = AG_ERROR;
					end else if ((selNow & groupArmed) == '0) begin
						d.error = 1'b1;
						d.fault = FC_NOT_ARMED;
						d.busy  = 1'b0;
						d.st    = AG_ERROR;
					end else if ((selNow & groupMoving) == '0) begin
						d.error = 1'b1;
						d.fault = FC_NOT_MOVING;
						d.busy  = 1'b0;
						d.st    = AG_ERROR;
					end else begin
						d.halt = selNow;
					end
				end
			end
			AG_START, AG_HALTING: begin
				if (q.st == AG_START) begin
					d.active = 1'b1;
					d.st     = AG_HALTING;
				end
				if (fall) begin
					d = '0;
					d.execPrev = 1'b0;
					d.inhibit  = q.inhibit & ~selHeld;
					d.st       = AG_IDLE;
				end else if ((selHeld & groupFail) != '0) begin
					d.error  = 1'b1;
					d.fault  = FC_EXEC_FAIL;
					d.busy   = 1'b0;
					d.active = 1'b0;
					d.halt   = '0;
					d.st     = AG_ERROR;
				end else if ((selHeld & groupAbort) != '0) begin
					d.aborted = 1'b1;
					d.busy    = 1'b0;
					d.active  = 1'b0;
					d.halt    = '0;
					d.st      = AG_ABORTED;
				end else if (q.st == AG_HALTING && (selHeld & groupStopped) != '0) begin
					// axes stay group moving; disarm is left to the requester
					d.done    = 1'b1;
					d.halt    = '0;
					d.inhibit = q.inhibit | selHeld;
					d.st      = AG_DONE;
				end
			end
			AG_DONE, AG_ABORTED, AG_ERROR: begin
				if (fall) begin
					d.busy    = 1'b0;
					d.active  = 1'b0;
					d.done    = 1'b0;
					d.aborted = 1'b0;
					d.error   = 1'b0;
					d.fault   = FC_NONE;
					d.inhibit = q.inhibit & ~selHeld;
					d.st      = AG_IDLE;
				end
			end
			default: begin
				d.st = AG_IDLE;
			end
		endcase
		// error falling takes done with it
		if (q.error && !d.error) begin
			d.done = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign busy        = q.busy;
	assign active      = q.active;
	assign done        = q.done;
	assign abortedFlag = q.aborted;
	assign error       = q.error;
	assign faultCode   = q.fault;
	assign groupHalt   = q.halt;
	assign moveInhibit = q.inhibit;

	always_comb begin
		rif.statusWord = '0;
		rif.statusWord[ST_BUSY]    = q.busy;
		rif.statusWord[ST_ACTIVE]  = q.active;
		rif.statusWord[ST_DONE]    = q.done;
		rif.statusWord[ST_ABORTED] = q.aborted;
		rif.statusWord[ST_ERROR]   = q.error;
		rif.statusWord[ST_INHIBIT] = |q.inhibit;
		rif.statusWord[ST_HALT]    = |q.halt;
	end
	assign rif.faultCode    = q.fault;
	assign rif.latchedGroup = q.grp;
endmodule

// File: bench/aghs_group_halt_props.sv
// aghs_group_halt_props: port-level checks of the halt handshake
// assumes: bound to aghs_group_halt, single core_clk domain
`timescale 1ns/1ps
module aghs_group_halt_props
	import aghs_pkg::*;
#(
	parameter int GROUPS = GROUP_MAX
) (
	// clock and reset
	input wire logic              core_clk,
	input wire logic              rst_n,
	// motion generator
	input wire logic [GROUPS-1:0] groupStopped,
	input wire logic [GROUPS-1:0] groupHalt,
	input wire logic [GROUPS-1:0] moveInhibit,
	// status
	input wire logic              busy,
	input wire logic              active,
	input wire logic              done,
	input wire logic              abortedFlag,
	input wire logic              error,
	input wire logic [15:0]       faultCode
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_active_late: assert property ($rose(active) |-> $past(busy))
		else $error("active rose without busy");
	a_busy_then: assert property ($rose(busy) |=> active || abortedFlag || error)
		else $error("active missing after busy");
	a_done_keeps: assert property (done |-> busy && active)
		else $error("done without busy and active");
	a_done_cause: assert property ($rose(done) |-> $past(groupStopped) != '0)
		else $error("done before motion stopped");
	a_abort_drops: assert property (abortedFlag |-> !busy && !active && !done)
		else $error("busy or active during abort");
	a_error_drops: assert property (error |-> !busy && !active && faultCode != FC_NONE)
		else $error("bad state during error");
	a_error_clear: assert property ($fell(error) |-> faultCode == FC_NONE && !done)
		else $error("fault code or done left after error");
	a_halt_busy: assert property (|groupHalt |-> busy && !done)
		else $error("halt outside busy");
	a_busy_halts: assert property ($rose(busy) |-> |groupHalt)
		else $error("busy rose without an immediate halt");
	a_inhibit_done: assert property (|moveInhibit |-> done)
		else $error("inhibit without done");
	a_halt_one: assert property ($onehot0(groupHalt))
		else $error("more than one group halted");
	c_done: cover property ($rose(done));
	c_abort: cover property ($rose(abortedFlag));
	c_error: cover property ($rose(error));
endmodule

// File: bench/aghs_motion_gen.sv
// aghs_motion_gen: behavioural motion generator facing the halt block
// assumes: bench sets arm and move requests; stop lands STOP_DLY+1 clocks after halt
`timescale 1ns/1ps
module aghs_motion_gen #(
	parameter int GROUPS   = 8,
	parameter int STOP_DLY = 4
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// bench requests
	input  wire logic [GROUPS-1:0] armReq,
	input  wire logic [GROUPS-1:0] moveReq,
	// block side
	input  wire logic [GROUPS-1:0] groupHalt,
	input  wire logic [GROUPS-1:0] moveInhibit,
	output logic [GROUPS-1:0]      groupArmed,
	output logic [GROUPS-1:0]      groupMoving,
	output logic [GROUPS-1:0]      groupStopped
);
	int cnt;
	assign groupArmed = armReq;
	// moving holds through the halt, axes never fall back to idle here
	assign groupMoving = moveReq & armReq;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			groupStopped <= '0;
		end else if (groupHalt == '0) begin
			cnt <= 0;
			if (moveInhibit == '0)
				groupStopped <= '0;
		end else if (cnt == STOP_DLY) begin
			groupStopped <= groupHalt;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// File: bench/test_aghs_group_halt.sv
// test_aghs_group_halt: apb driven sequences against the halt block
// assumes: zero or more wait state apb slave, motion generator model
`timescale 1ns/1ps
module test_aghs_group_halt;
	import aghs_pkg::*;
	logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, se;
	logic        busy, active, done, abortedFlag, error;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] faultCode;
	logic [7:0]  armReq, moveReq, groupAbort, groupFail, groupArmed, groupMoving;
	logic [7:0]  groupStopped, groupHalt, moveInhibit;
	int          error_cnt, num_checks;
	localparam logic [7:0]  GRP [5] = '{8'h00, 8'h09, 8'h03, 8'h03, 8'h03};
	localparam logic [7:0]  POL [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
	localparam logic [7:0]  ARM [5] = '{8'h04, 8'h04, 8'h04, 8'h00, 8'h04};
	localparam logic [7:0]  MOV [5] = '{8'h04, 8'h04, 8'h04, 8'h00, 8'h00};
	localparam logic [15:0] FCS [5] = '{FC_BAD_GROUP, FC_BAD_GROUP, FC_BAD_POLICY,
		FC_NOT_ARMED, FC_NOT_MOVING};
	aghs_group_halt aghs_group_halt_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .groupArmed(groupArmed),
		.groupMoving(groupMoving), .groupStopped(groupStopped), .groupAbort(groupAbort),
		.groupFail(groupFail), .groupHalt(groupHalt), .moveInhibit(moveInhibit),
		.busy(busy), .active(active), .done(done), .abortedFlag(abortedFlag),
		.error(error), .faultCode(faultCode));
	aghs_motion_gen aghs_motion_gen_i (.core_clk(core_clk), .rst_n(rst_n), .armReq(armReq),
		.moveReq(moveReq), .groupHalt(groupHalt), .moveInhibit(moveInhibit),
		.groupArmed(groupArmed), .groupMoving(groupMoving), .groupStopped(groupStopped));
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			final_report();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input logic [7:0] g, input logic [7:0] p, input logic [31:0] st,
		input logic [15:0] fc);
		int n;
		apb(1'b1, OFS_CFG, {8'hA5, 8'h5A, p, g});
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			n++;
		end while (rd[4:2] == 3'b000 && n < 30);
		if (n == 30) begin
			error_cnt++;
			final_report();
		end
		chk(rd, st);
		apb(1'b0, OFS_FAULT, 32'h0000_0000);
		chk(rd, {16'h0000, fc});
		chk({16'h0000, faultCode}, {16'h0000, fc});
		chk({27'h000_0000, error, abortedFlag, done, active, busy}, {27'h000_0000, st[4:0]});
	endtask
	task automatic release_cmd();
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd, RST_WORD);
		chk({16'h0000, faultCode}, 32'h0000_0000);
		chk({27'h000_0000, error, abortedFlag, done, active, busy}, 32'h0000_0000);
		chk({16'h0000, groupHalt, moveInhibit}, 32'h0000_0000);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{armReq, moveReq, groupAbort, groupFail} = '0;
		error_cnt = 0;
		num_checks = 0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd, RST_WORD);
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk({31'h0000_0000, se}, 32'h0000_0001);
		armReq <= 8'h04;
		moveReq <= 8'h04;
		run(8'h03, POL_ABORT, 32'h0000_0027, FC_NONE);
		chk({24'h00_0000, moveInhibit}, 32'h0000_0004);
		chk({24'h00_0000, groupMoving}, 32'h0000_0004);
		apb(1'b1, OFS_CFG, 32'h0000_0005);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		apb(1'b0, OFS_GROUP, 32'h0000_0000);
		chk(rd, 32'h0000_0003);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0027);
		release_cmd();
		$display("test normal halt finished");
		for (int i = 0; i < 5; i++) begin
			armReq <= ARM[i];
			moveReq <= MOV[i];
			run(GRP[i], POL[i], 32'h0000_0010, FCS[i]);
			release_cmd();
		end
		$display("test illegal inputs finished");
		armReq <= 8'h04;
		moveReq <= 8'h04;
		groupAbort <= 8'h04;
		run(8'h03, POL_ABORT, 32'h0000_0008, FC_NONE);
		release_cmd();
		groupAbort <= 8'h00;
		groupFail <= 8'h04;
		run(8'h03, POL_ABORT, 32'h0000_0010, FC_EXEC_FAIL);
		release_cmd();
		groupFail <= 8'h00;
		armReq <= 8'h00;
		$display("test abort and fail finished");
		final_report();
	end
endmodule
bind aghs_group_halt aghs_group_halt_props #(.GROUPS(GROUPS)) aghs_group_halt_props_i (
	.core_clk(core_clk), .rst_n(rst_n), .groupStopped(groupStopped),
	.groupHalt(groupHalt), .moveInhibit(moveInhibit), .busy(busy), .active(active),
	.done(done), .abortedFlag(abortedFlag), .error(error), .faultCode(faultCode));
